// >>> lrc_host.sv
`timescale 1ns/1ns
// ---------------------------------------------
// Host model on the register port
// ---------------------------------------------
module lrc_host (
  input  wire logic        mclk,
  output lrc_pkg::lrc_req_t req,
  input  wire logic [7:0]  rdata,
  input  wire logic        ack,
  input  wire logic        hit
);
  import lrc_pkg::*;

  // Bus starts idle
  initial req = '0;

  // Released bus shows inverted values, so stale data never matches
  task automatic release_bus(input logic [7:0] a, input logic [7:0] d);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  // One write strobe; a rewrite while the rail is on is legal
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    release_bus(a, d);
  endtask

  // One read strobe; answer taken in the cycle after the strobe
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                          output logic ak, output logic h);
    @(posedge mclk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    #1 h = hit;
    @(posedge mclk);
    release_bus(a, 8'h00);
    #1 ak = ack;
    d = rdata;
  endtask
endmodule // lrc_host

// >>> lrc_pkg.sv
package lrc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] LRC_FAST_CTRL_ADDR = 8'h08;
  localparam logic [7:0] LRC_LN_CTRL_ADDR   = 8'h09;

  // Field positions inside a control byte
  localparam int LRC_EN_BIT   = 5;
  localparam int LRC_VSEL_MSB = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic       LRC_FAST_EN_RST   = 1'b1;
  localparam logic       LRC_LN_EN_RST     = 1'b0;
  localparam logic [4:0] LRC_FAST_VSEL_RST = 5'h06;
  localparam logic [4:0] LRC_LN_VSEL_RST   = 5'h14;

  // ----------------------------------------------------------------
  // Voltage code mapping, in millivolts
  // ----------------------------------------------------------------
  localparam logic [11:0] LRC_FAST_BASE_MV = 12'h4b0;
  localparam logic [11:0] LRC_LN_BASE_MV   = 12'h514;
  localparam logic [11:0] LRC_STEP_MV      = 12'h064;
  localparam logic [11:0] LRC_MAX_MV       = 12'hce4;
  localparam logic [4:0]  LRC_FAST_SAT     = 5'h15;
  localparam logic [4:0]  LRC_LN_SAT       = 5'h14;

  // Control byte as stored; reserved bits always zero
  typedef struct packed {
    logic [1:0] rsv;
    logic       en;
    logic [4:0] vsel;
  } lrc_ctrl_t;

  // Register access from the serial interface back end
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lrc_req_t;

  // Controls toward one analog rail
  typedef struct packed {
    logic        on;
    logic        shunt;
    logic [4:0]  code;
    logic [11:0] mv;
  } lrc_rail_t;

  // Code to output millivolts, saturating at the top code range
  function automatic logic [11:0] lrc_code_mv(input logic [11:0] base,
                                              input logic [4:0]  sat,
                                              input logic [4:0]  code);
    logic [11:0] step;
    step = 12'(LRC_STEP_MV * {7'h00, code});
    if (code >= sat) begin
      return LRC_MAX_MV;
    end
    return 12'(base + step);
  endfunction

endpackage

// >>> lrc_rail_ctl.sv
`timescale 1ns/1ns
// ------------------------------------------------------------------
// Enable and shunt control for one rail
// ------------------------------------------------------------------
module lrc_rail_ctl #(
  parameter bit PIN_CTRL = 1'b0
) (
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic en_bit,
  input  wire logic en_pin,
  input  wire logic seq_done,
  output logic      on_r,
  output logic      shunt_r
);
  import lrc_pkg::*;

  logic on_nxt;
  logic shunt_nxt;

  // Bit forces on; with bit low the pin decides, if this rail has one
  always_comb begin
    on_nxt    = seq_done & (en_bit | (PIN_CTRL & en_pin));
    shunt_nxt = ~on_nxt;
  end

  // Rail held off and shunted during reset
  always_ff @(posedge mclk) begin
    if (srst) begin
      on_r    <= 1'b0;
      shunt_r <= 1'b1;
    end else begin
      on_r    <= on_nxt;
      shunt_r <= shunt_nxt;
    end
  end

endmodule // lrc_rail_ctl

// >>> lrc_top.sv
// How it works
// - Fast code 0 is 1.2V, 0x15+ 3.3V
// - Fast enable bit 5 switches rail
// - Fast enable bit resets to one
// - Low-noise code 0 is 1.3V, 0x14+ 3.3V
// - Low-noise enable bit resets to zero
// - Low-noise bit zero hands control to pin
// - Pin high on, pin low off
// - Low-noise bit one forces rail on
// - Voltage rewrite applies while rail enabled
// - Low-noise off drives shunt to analog ground
// - Pin high at power-up joins fast sequencing
`timescale 1ns/1ns
module lrc_top #(
  parameter logic [4:0] FAST_VSEL_RST = lrc_pkg::LRC_FAST_VSEL_RST,
  parameter logic [4:0] LN_VSEL_RST   = lrc_pkg::LRC_LN_VSEL_RST
) (
  input  wire logic              mclk,
  input  wire logic              srst,
  input  wire lrc_pkg::lrc_req_t reg_req,
  output logic      [7:0]        reg_rdata,
  output logic                   reg_ack,
  output logic                   reg_hit,
  input  wire logic              low_noise_reg_enable_pin,
  input  wire logic              por_seq_done,
  output lrc_pkg::lrc_rail_t     fast_regulator_rail,
  output lrc_pkg::lrc_rail_t     low_noise_regulator_rail
);
  import lrc_pkg::*;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Decoded once, shared by write, read-back and hit logic
  // Bit 0 selects fast, bit 1 low-noise; zero means unmapped
  function automatic logic [1:0] reg_sel(input logic [7:0] addr);
    reg_sel = {addr == LRC_LN_CTRL_ADDR, addr == LRC_FAST_CTRL_ADDR};
  endfunction

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  lrc_ctrl_t ctrl_r   [2];
  lrc_ctrl_t ctrl_nxt [2];
  logic [1:0] sel;

  assign sel = reg_sel(reg_req.addr);

  // Writes store enable and code; reserved bits are never stored
  // A write to an unmapped address falls through and changes nothing
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      ctrl_nxt[i] = ctrl_r[i];
      if (reg_req.wr && sel[i]) begin
        ctrl_nxt[i].en   = reg_req.wdata[LRC_EN_BIT];
        ctrl_nxt[i].vsel = reg_req.wdata[LRC_VSEL_MSB:0];
      end
      ctrl_nxt[i].rsv = 2'b00;
    end
  end

  // Reset values: fast on, low-noise under pin control
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_r[0] <= '{rsv: 2'b00, en: LRC_FAST_EN_RST, vsel: FAST_VSEL_RST};
      ctrl_r[1] <= '{rsv: 2'b00, en: LRC_LN_EN_RST, vsel: LN_VSEL_RST};
    end else begin
      ctrl_r[0] <= ctrl_nxt[0];
      ctrl_r[1] <= ctrl_nxt[1];
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [7:0] rdata_nxt;
  logic [7:0] rdata_r;
  logic       ack_nxt;
  logic       ack_r;

  // Unmapped reads return zero; hit flags whether the address exists
  // Data then holds until the next read, so a slow host may take it late
  // With write and read together the read sees the old contents
  always_comb begin
    rdata_nxt = rdata_r;
    ack_nxt   = reg_req.rd;
    if (reg_req.rd) begin
      rdata_nxt = 8'h00;
      for (int i = 0; i < 2; i++) begin
        if (sel[i]) begin
          rdata_nxt = {2'b00, ctrl_r[i].en, ctrl_r[i].vsel};
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rdata_r <= 8'h00;
      ack_r   <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      ack_r   <= ack_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_ack   = ack_r;
  assign reg_hit   = |sel;

  // ----------------------------------------------------------------
  // Rail channels
  // ----------------------------------------------------------------
  logic [1:0]  on_w;
  logic [1:0]  shunt_w;
  logic [11:0] mv_w [2];

  // Only the low-noise rail has an external enable pin
  // Millivolts come from a register, so they trail the code by a cycle
  generate
    for (genvar g = 0; g < 2; g++) begin : g_rail
      lrc_rail_ctl #(
        .PIN_CTRL (g == 1)
      ) u_ctl (
        .mclk     (mclk),
        .srst     (srst),
        .en_bit   (ctrl_r[g].en),
        .en_pin   (low_noise_reg_enable_pin),
        .seq_done (por_seq_done),
        .on_r     (on_w[g]),
        .shunt_r  (shunt_w[g])
      );
      lrc_vsel #(
        .BASE_MV (g == 0 ? LRC_FAST_BASE_MV : LRC_LN_BASE_MV),
        .SAT     (g == 0 ? LRC_FAST_SAT : LRC_LN_SAT)
      ) u_vsel (
        .mclk (mclk),
        .srst (srst),
        .code (ctrl_r[g].vsel),
        .mv_r (mv_w[g])
      );
    end
  endgenerate

  // Gather flopped controls into the rail carriers
  assign fast_regulator_rail      = '{on: on_w[0], shunt: shunt_w[0],
                                      code: ctrl_r[0].vsel, mv: mv_w[0]};
  assign low_noise_regulator_rail = '{on: on_w[1], shunt: shunt_w[1],
                                      code: ctrl_r[1].vsel, mv: mv_w[1]};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // One clock for every property; reset silences them all
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  logic fast_on;
  logic ln_on;
  logic ln_wr_force;

  assign fast_on     = fast_regulator_rail.on;
  assign ln_on       = low_noise_regulator_rail.on;
  assign ln_wr_force = reg_req.wr && reg_req.addr == LRC_LN_CTRL_ADDR
                       && reg_req.wdata[LRC_EN_BIT];

  // ----------------------------------------------------------------
  // Rail checks
  // ----------------------------------------------------------------
  // Target millivolts trail the stored code by one register stage
  chk_fast_code_map: assert property (
    !$past(srst) |-> fast_regulator_rail.mv ==
      lrc_code_mv(LRC_FAST_BASE_MV, LRC_FAST_SAT, $past(ctrl_r[0].vsel)))
    else $error("fast rail millivolts do not match code");

  chk_ln_code_map: assert property (
    !$past(srst) |-> low_noise_regulator_rail.mv ==
      lrc_code_mv(LRC_LN_BASE_MV, LRC_LN_SAT, $past(ctrl_r[1].vsel)))
    else $error("low-noise rail millivolts do not match code");

  chk_fast_en_follow: assert property (
    !$past(srst) |-> fast_on == ($past(por_seq_done) && $past(ctrl_r[0].en)))
    else $error("fast rail enable does not follow its bit");

  // Both registers leave reset at their build-time values
  chk_reset_values: assert property (
    $fell(srst) |-> ctrl_r[0].en && !ctrl_r[1].en
      && ctrl_r[0].vsel == FAST_VSEL_RST && ctrl_r[1].vsel == LN_VSEL_RST)
    else $error("control registers not at reset values");

  // With the bit low, the pin level one cycle earlier decides
  chk_ln_pin_ctrl: assert property (
    !$past(srst) && !$past(ctrl_r[1].en) && $past(por_seq_done)
      |-> ln_on == $past(low_noise_reg_enable_pin))
    else $error("low-noise rail does not follow its pin");

  // A forcing write wins over a low pin two cycles later
  chk_ln_force_on: assert property (
    ln_wr_force && por_seq_done ##1 por_seq_done |-> ##1 ln_on [*2])
    else $error("low-noise rail not forced on by its bit");

  // Code lands a cycle after the write and millivolts one later; a second
  // write in between is legal, so the target follows the stored code
  chk_vsel_live: assert property (
    reg_req.wr && reg_req.addr == LRC_FAST_CTRL_ADDR && fast_on
      |-> ##1 fast_regulator_rail.code == $past(reg_req.wdata[4:0])
      ##1 fast_regulator_rail.mv ==
        lrc_code_mv(LRC_FAST_BASE_MV, LRC_FAST_SAT, $past(fast_regulator_rail.code)))
    else $error("voltage rewrite not applied while enabled");

  chk_ln_vsel_live: assert property (
    reg_req.wr && reg_req.addr == LRC_LN_CTRL_ADDR && ln_on
      |-> ##1 low_noise_regulator_rail.code == $past(reg_req.wdata[4:0])
      ##1 low_noise_regulator_rail.mv ==
        lrc_code_mv(LRC_LN_BASE_MV, LRC_LN_SAT, $past(low_noise_regulator_rail.code)))
    else $error("low-noise voltage rewrite not applied while enabled");

  // Worked out from the inputs, so a wrong on flop cannot hide a wrong shunt
  chk_ln_shunt: assert property (
    !$past(srst) |-> low_noise_regulator_rail.shunt == !($past(por_seq_done)
      && ($past(ctrl_r[1].en) || $past(low_noise_reg_enable_pin))))
    else $error("low-noise shunt not set while rail is off");

  chk_fast_shunt: assert property (
    !$past(srst) |-> fast_regulator_rail.shunt == !($past(por_seq_done)
      && $past(ctrl_r[0].en)))
    else $error("fast shunt not set while rail is off");

  // Pin high as the fast rail rises: both rails start together
  chk_ln_seq_align: assert property (
    $rose(fast_on) && $past(low_noise_reg_enable_pin) |-> ln_on)
    else $error("low-noise rail not sequenced with fast rail");

  // Reserved pair never stored and never read back
  chk_rsv_zero: assert property (
    reg_ack |-> reg_rdata[7:6] == 2'b00 && ctrl_r[0].rsv == 2'b00
      && ctrl_r[1].rsv == 2'b00)
    else $error("reserved bits not zero");

  // ----------------------------------------------------------------
  // Register port checks
  // ----------------------------------------------------------------
  // Answer is a single pulse one cycle after the strobe, never on its own
  chk_ack_pulse: assert property (
    !$past(srst) |-> reg_ack == $past(reg_req.rd))
    else $error("read answer not one cycle after strobe");

  // Read-back shows the stored bits with the reserved pair forced low
  chk_fast_read: assert property (
    reg_req.rd && reg_req.addr == LRC_FAST_CTRL_ADDR
      |=> reg_rdata == {2'b00, $past(ctrl_r[0].en), $past(ctrl_r[0].vsel)})
    else $error("fast register read-back wrong");

  chk_ln_read: assert property (
    reg_req.rd && reg_req.addr == LRC_LN_CTRL_ADDR
      |=> reg_rdata == {2'b00, $past(ctrl_r[1].en), $past(ctrl_r[1].vsel)})
    else $error("low-noise register read-back wrong");

  // Nothing lives at other addresses, so their reads come back empty
  chk_unmapped_zero: assert property (
    reg_req.rd && !reg_hit |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  // Between reads the answer must not drift
  chk_rdata_hold: assert property (
    !reg_req.rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  // A register only moves on a write aimed at it
  chk_fast_hold: assert property (
    !(reg_req.wr && sel[0]) |=> ctrl_r[0] == $past(ctrl_r[0]))
    else $error("fast register changed without a write");

  chk_ln_hold: assert property (
    !(reg_req.wr && sel[1]) |=> ctrl_r[1] == $past(ctrl_r[1]))
    else $error("low-noise register changed without a write");

  // Neither rail may come up before the power-on sequence point
  chk_off_before_seq: assert property (
    !$past(srst) && !$past(por_seq_done) |-> !fast_on && !ln_on)
    else $error("rail on before power-on sequence point");

  // Fast rail has no pin: a clear bit keeps it off whatever the pin does
  chk_fast_pin_free: assert property (
    !$past(srst) && !$past(ctrl_r[0].en) |-> !fast_on)
    else $error("fast rail on with its bit clear");

  // ----------------------------------------------------------------
  // Coverage of the main scenarios
  // ----------------------------------------------------------------
  // Each marks a scenario that the bench is meant to reach
  cov_fast_rewrite: cover property (
    reg_req.wr && reg_req.addr == LRC_FAST_CTRL_ADDR && fast_on);
  cov_ln_forced: cover property (
    ln_wr_force && !low_noise_reg_enable_pin ##2 ln_on);
  cov_ln_by_pin: cover property (
    !ctrl_r[1].en && $rose(ln_on));
  cov_read_rsv: cover property (
    reg_req.rd && reg_req.addr == LRC_LN_CTRL_ADDR ##1 reg_ack);
  cov_seq_join: cover property (
    $rose(fast_on) && $rose(ln_on));

endmodule // lrc_top

// >>> lrc_top_test.sv
`timescale 1ns/1ns
module lrc_top_test;
  import lrc_pkg::*;
  logic       mclk     = 1'b0;
  logic       srst     = 1'b1;
  logic       en_pin   = 1'b0;
  logic       seq_done = 1'b1;
  lrc_req_t   req;
  logic [7:0] rdata;
  logic       ack;
  logic       hit;
  lrc_rail_t  fr;
  lrc_rail_t  lr;
  int         fails       = 0;
  int         checks_done = 0;

  // 250 MHz clock
  always #2 mclk = ~mclk;

  lrc_top u_lrc_top (
    .mclk                     (mclk),
    .srst                     (srst),
    .reg_req                  (req),
    .reg_rdata                (rdata),
    .reg_ack                  (ack),
    .reg_hit                  (hit),
    .low_noise_reg_enable_pin (en_pin),
    .por_seq_done             (seq_done),
    .fast_regulator_rail      (fr),
    .low_noise_regulator_rail (lr)
  );

  lrc_host u_lrc_host (
    .mclk  (mclk),
    .req   (req),
    .rdata (rdata),
    .ack   (ack),
    .hit   (hit)
  );

  // -------------------------
  // Compare helpers
  // -------------------------
  task automatic ck(input logic [11:0] got, input logic [11:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Linear code to millivolts, saturating at 3300
  function automatic logic [11:0] exp_mv(input logic [11:0] base, input logic [4:0] sat,
                                         input logic [4:0] c);
    return (c >= sat) ? 12'hce4 : 12'(base + 12'h064 * {7'h00, c});
  endfunction

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic exp_hit);
    logic [7:0] d;
    logic       ak;
    logic       h;
    u_lrc_host.read_reg(a, d, ak, h);
    ck({4'h0, d}, {4'h0, exp}, "read data");
    ck({11'h0, ak}, 12'h001, "read ack");
    ck({11'h0, h}, {11'h0, exp_hit}, "address hit");
    settle();
    ck({11'h0, ack}, 12'h000, "ack lasts one cycle");
    ck({4'h0, rdata}, {4'h0, exp}, "read data held");
  endtask

  // Shunt must always be the inverse of the rail being on
  task automatic rail_chk(input lrc_rail_t r, input logic on, input logic [11:0] mv,
                          input string what);
    ck({11'h0, r.on}, {11'h0, on}, what);
    ck({11'h0, r.shunt}, {11'h0, ~on}, what);
    ck(r.mv, mv, what);
  endtask

  task automatic settle;
    @(posedge mclk);
    #1;
  endtask

  // -------------------------
  // Scenarios
  // -------------------------
  task automatic t_reset;
    rail_chk(fr, 1'b1, 12'h708, "fast after reset");
    rail_chk(lr, 1'b0, 12'hce4, "low-noise after reset");
    rd_chk(8'h08, 8'h26, 1'b1);
    rd_chk(8'h09, 8'h14, 1'b1);
  endtask

  // Every code with reserved bits set and enable on; pin stays low
  task automatic t_sweep(input logic [7:0] a, input logic [11:0] base, input logic [4:0] sat);
    for (int c = 0; c < 32; c++) begin
      u_lrc_host.write_reg(a, 8'he0 | 8'(c));
      settle();
      rail_chk((a == 8'h08) ? fr : lr, 1'b1, exp_mv(base, sat, 5'(c)), "sweep");
      ck({7'h0, ((a == 8'h08) ? fr.code : lr.code)}, 12'(c), "rail code");
      rd_chk(a, 8'h20 | 8'(c), 1'b1);
    end
  endtask

  task automatic t_fast_off;
    u_lrc_host.write_reg(8'h08, 8'h06);
    settle();
    rail_chk(fr, 1'b0, 12'h708, "fast off");
    u_lrc_host.write_reg(8'h08, 8'h2a);
    settle();
    rail_chk(fr, 1'b1, 12'h898, "fast on");
  endtask

  task automatic t_pin;
    u_lrc_host.write_reg(8'h09, 8'h03);
    settle();
    rail_chk(lr, 1'b0, 12'h640, "pin low");
    @(posedge mclk);
    en_pin <= 1'b1;
    settle();
    rail_chk(lr, 1'b1, 12'h640, "pin high");
    @(posedge mclk);
    en_pin <= 1'b0;
    settle();
    rail_chk(lr, 1'b0, 12'h640, "pin low again");
    u_lrc_host.write_reg(8'h09, 8'h23);
    settle();
    rail_chk(lr, 1'b1, 12'h640, "forced on");
  endtask

  // Unmapped places neither store nor alias onto the real registers
  task automatic t_unmapped;
    u_lrc_host.write_reg(8'h0a, 8'h3f);
    rd_chk(8'h0a, 8'h00, 1'b0);
    rd_chk(8'h07, 8'h00, 1'b0);
    rd_chk(8'h08, 8'h2a, 1'b1);
    rd_chk(8'h09, 8'h23, 1'b1);
  endtask

  // Pin held high through power-up: both rails wait for the sequencer
  task automatic t_por;
    @(posedge mclk);
    srst     <= 1'b1;
    seq_done <= 1'b0;
    en_pin   <= 1'b1;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    rail_chk(fr, 1'b0, 12'h708, "fast before sequence");
    rail_chk(lr, 1'b0, 12'hce4, "low-noise before sequence");
    @(posedge mclk);
    seq_done <= 1'b1;
    settle();
    rail_chk(fr, 1'b1, 12'h708, "fast sequenced");
    rail_chk(lr, 1'b1, 12'hce4, "low-noise sequenced");
    settle();
    rail_chk(lr, 1'b1, 12'hce4, "low-noise stays on");
  endtask

  task automatic test_done;
    $display("Checks: %0d, mismatches: %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    test_done();
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    t_reset();
    t_sweep(8'h08, 12'h4b0, 5'h15);
    t_sweep(8'h09, 12'h514, 5'h14);
    t_fast_off();
    t_pin();
    t_unmapped();
    t_por();
    test_done();
  end
endmodule // lrc_top_test

// >>> lrc_vsel.sv
`timescale 1ns/1ns
// ------------------------------------------------------------------
// Voltage code decoder, registered
// ------------------------------------------------------------------
module lrc_vsel #(
  parameter logic [11:0] BASE_MV = lrc_pkg::LRC_FAST_BASE_MV,
  parameter logic [4:0]  SAT     = lrc_pkg::LRC_FAST_SAT
) (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic [4:0]  code,
  output logic      [11:0] mv_r
);
  import lrc_pkg::*;

  logic [11:0] mv_nxt;

  // Applied every cycle, so a new code takes effect while enabled
  always_comb begin
    mv_nxt = lrc_code_mv(BASE_MV, SAT, code);
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      mv_r <= 12'h000;
    end else begin
      mv_r <= mv_nxt;
    end
  end

endmodule // lrc_vsel
